// File: core/ppwm_pkg.sv
// ppwm_pkg: register map, field positions and shared types for one power pwm channel.
// assumes a 16-bit register port and a single 40 MHz clock.
package ppwm_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_DUTY  = 4'h1;
  localparam logic [3:0] ADDR_PHASE = 4'h2;
  localparam logic [3:0] ADDR_DT    = 4'h3;
  localparam logic [3:0] ADDR_ALTDT = 4'h4;
  localparam logic [3:0] ADDR_TRG   = 4'h5;
  localparam logic [3:0] ADDR_IO    = 4'h6;
  localparam logic [3:0] ADDR_MDUTY = 4'h7;
  localparam logic [3:0] ADDR_PTPER = 4'h8;
  localparam logic [3:0] ADDR_FLT   = 4'h9;

  // writable masks; unimplemented bits read zero
  localparam logic [15:0] MASK_CTRL  = 16'h0FC3;
  localparam logic [15:0] MASK_PHASE = 16'hFFFC;
  localparam logic [15:0] MASK_DT    = 16'h3FFC;
  localparam logic [15:0] MASK_TRG   = 16'hE03F;
  localparam logic [15:0] MASK_IO    = 16'hFFFD;
  localparam logic [15:0] MASK_PER   = 16'hFFF8;
  localparam logic [15:0] MASK_ITB   = 16'hFFF0;
  localparam logic [15:0] MASK_FLT   = 16'h0083;

  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] RST_DUTY  = 16'h0008;
  localparam logic [15:0] RST_PER   = 16'hFFF8;
  localparam logic [15:0] ONE16     = 16'h0001;
  localparam logic [2:0]  ZERO3     = 3'h0;
  localparam logic [2:0]  ONE3      = 3'h1;
  localparam logic [5:0]  ZERO6     = 6'h00;
  localparam logic [5:0]  ONE6      = 6'h01;
  localparam logic [11:0] ZERO12    = 12'h000;
  localparam logic [11:0] ONE12     = 12'h001;

  // control register bits
  localparam int unsigned B_LIM_PEND = 14;
  localparam int unsigned B_TRG_PEND = 13;
  localparam int unsigned B_LIM_IEN  = 11;
  localparam int unsigned B_TRG_IEN  = 10;
  localparam int unsigned B_ITB      = 9;
  localparam int unsigned B_MASTER_DUTY_SELECT     = 8;
  localparam int unsigned B_DTM_HI   = 7;
  localparam int unsigned B_DTM_LO   = 6;
  localparam int unsigned B_XRES     = 1;
  localparam int unsigned B_IUE      = 0;
  // dead-time registers: value field starts here
  localparam int unsigned B_DT_LO    = 2;
  // trigger control
  localparam int unsigned B_TDIV_HI  = 15;
  localparam int unsigned B_TDIV_LO  = 13;
  localparam int unsigned B_TSTRT_HI = 5;
  // output pin control
  localparam int unsigned B_HIGH_PIN_OWNER  = 15;
  localparam int unsigned B_LOW_PIN_OWNER  = 14;
  localparam int unsigned B_HIGH_PIN_INVERT  = 13;
  localparam int unsigned B_POLL  = 12;
  localparam int unsigned B_PIN_PAIR_MODE_HI = 11;
  localparam int unsigned B_PIN_PAIR_MODE_LO = 10;
  localparam int unsigned B_OVRH  = 9;
  localparam int unsigned B_OVRL  = 8;
  localparam int unsigned B_OVD_HI = 7;
  localparam int unsigned B_OVD_LO = 6;
  localparam int unsigned B_FLD_HI = 5;
  localparam int unsigned B_FLD_LO = 4;
  localparam int unsigned B_CLD_HI = 3;
  localparam int unsigned B_CLD_LO = 2;
  localparam int unsigned B_FORCE_SYNC_SELECT  = 0;
  // fault/limit control (own register)
  localparam int unsigned B_LIM_EN  = 7;
  localparam int unsigned B_FMOD_HI = 1;
  localparam int unsigned B_FMOD_LO = 0;

  typedef enum logic [1:0] {DT_POS, DT_NEG, DT_OFF, DT_RSV} ppwm_dtmode_t;
  typedef enum logic [1:0] {PM_COMP, PM_INDEP, PM_PUSH, PM_RSV} ppwm_pmode_t;
  typedef enum logic [1:0] {FM_LATCH, FM_CYCLE, FM_RSV, FM_OFF} ppwm_fmode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ppwm_bus_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } ppwm_pair_t;
endpackage

// File: core/ppwm_deadtime.sv
// ppwm_deadtime: turns one raw pwm waveform into a high/low pair with dead time.
// assumes a single clock; dead-time counts are in clock cycles.
module ppwm_deadtime
  import ppwm_pkg::*;
#(
  parameter int unsigned DT_W = 12
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           raw,
  input  wire ppwm_dtmode_t   mode,
  input  wire logic [DT_W-1:0] dt_rise,
  input  wire logic [DT_W-1:0] dt_fall,
  output ppwm_pair_t          pair
);
  logic            raw_d_r;
  logic [DT_W-1:0] cnt_r;
  logic            hi_r;
  logic            lo_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      raw_d_r <= 1'b0;
    end else begin
      raw_d_r <= raw;
    end
  end

  // edge reloads the gap; in DT_POS both outputs stay off while it runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= ZERO12[DT_W-1:0];
    end else if (raw != raw_d_r) begin
      cnt_r <= raw ? dt_rise : dt_fall;
    end else if (cnt_r != ZERO12[DT_W-1:0]) begin
      cnt_r <= cnt_r - ONE12[DT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else begin
      case (mode)
        DT_POS: begin
          // gap inserted before each turn-on
          hi_r <= raw && (raw == raw_d_r) && (cnt_r == ZERO12[DT_W-1:0]);
          lo_r <= !raw && (raw == raw_d_r) && (cnt_r == ZERO12[DT_W-1:0]);
        end
        DT_NEG: begin
          // overlap: the leaving switch is held on during the gap
          hi_r <= raw || (cnt_r != ZERO12[DT_W-1:0] && !raw);
          lo_r <= !raw || (cnt_r != ZERO12[DT_W-1:0] && raw);
        end
        DT_OFF: begin
          hi_r <= raw;
          lo_r <= !raw;
        end
        default: begin
          hi_r <= 1'b0;
          lo_r <= 1'b0;
        end
      endcase
    end
  end

  assign pair.hi = hi_r;
  assign pair.lo = lo_r;
endmodule

// File: core/ppwm_channel.sv
// ppwm_channel: one generator channel of a power-supply pwm unit with its register file.
// assumes a synchronous register port (read data one cycle later) and a single clock.
//
// The implementer's own choices: strobed register access and the register addresses.
module ppwm_channel
  import ppwm_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned DT_W  = 12
) (
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              LIMIT_IN,
  input  wire logic              FAULT_IN,
  input  wire logic              GPIO_HIGH,
  input  wire logic              GPIO_LOW,
  output logic                   HIGH_OUTPUT_PIN,
  output logic                   LOW_OUTPUT_PIN,
  output logic                   TRIGGER_OUT,
  output logic                   LIMIT_IRQ,
  output logic                   TRIGGER_IRQ
);
  ppwm_bus_t bus;
  assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  logic [15:0] ctrl_r, duty_r, phase_r, dt_r, altdt_r, trg_r, io_r, mduty_r, ptper_r, flt_r;
  logic [15:0] act_duty_r, rdata_r;
  logic [CNT_W-1:0] tb_cnt_r;
  logic [5:0]  roll_r;
  logic [2:0]  div_cnt_r;
  logic        post_en_r, trig_out_r, fault_lat_r;
  ppwm_pair_t  force_act_r, pins_r;
  logic        limit_pend_r, trg_pend_r, duty_pend_r;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_a);
    return bus.wr && (a == reg_a);
  endfunction

  // time base: independent period ignores low bits
  logic [15:0] period;
  logic        boundary, trig_evt, ext_reset;
  assign period = ctrl_r[B_ITB] ? (phase_r & MASK_ITB) : ptper_r;
  assign ext_reset = ctrl_r[B_XRES] && ctrl_r[B_ITB] && LIMIT_IN;
  assign boundary = (tb_cnt_r >= period[CNT_W-1:0]) || ext_reset;
  // trigger event when time base equals the phase value; zero phase never fires
  assign trig_evt = (tb_cnt_r == phase_r[CNT_W-1:0]) && (phase_r != RST_ZERO);

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      tb_cnt_r <= '0;
    end else if (boundary) begin
      tb_cnt_r <= '0;
    end else begin
      tb_cnt_r <= tb_cnt_r + ONE16[CNT_W-1:0];
    end
  end

  // register writes, masked so unimplemented bits never store
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ctrl_r  <= RST_ZERO;
      duty_r  <= RST_DUTY;
      phase_r <= RST_ZERO;
      dt_r    <= RST_ZERO;
      altdt_r <= RST_ZERO;
      trg_r   <= RST_ZERO;
      io_r    <= RST_ZERO;
      mduty_r <= RST_DUTY;
      ptper_r <= RST_PER;
      flt_r   <= RST_ZERO;
    end else begin
      if (hit(bus.addr, ADDR_CTRL))  ctrl_r  <= bus.wdata & MASK_CTRL;
      if (hit(bus.addr, ADDR_DUTY))  duty_r  <= bus.wdata;
      if (hit(bus.addr, ADDR_PHASE)) phase_r <= bus.wdata & MASK_PHASE;
      if (hit(bus.addr, ADDR_DT))    dt_r    <= bus.wdata & MASK_DT;
      if (hit(bus.addr, ADDR_ALTDT)) altdt_r <= bus.wdata & MASK_DT;
      if (hit(bus.addr, ADDR_TRG))   trg_r   <= bus.wdata & MASK_TRG;
      if (hit(bus.addr, ADDR_IO))    io_r    <= bus.wdata & MASK_IO;
      if (hit(bus.addr, ADDR_MDUTY)) mduty_r <= bus.wdata;
      if (hit(bus.addr, ADDR_PTPER)) ptper_r <= bus.wdata & MASK_PER;
      if (hit(bus.addr, ADDR_FLT))   flt_r   <= bus.wdata & MASK_FLT;
    end
  end

  // active duty: immediate or held until the period boundary
  logic [15:0] duty_src;
  assign duty_src = ctrl_r[B_MASTER_DUTY_SELECT] ? mduty_r : duty_r;
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      act_duty_r  <= RST_DUTY;
      duty_pend_r <= 1'b0;
    end else if (ctrl_r[B_IUE]) begin
      act_duty_r  <= duty_src;
      duty_pend_r <= 1'b0;
    end else if (boundary) begin
      act_duty_r  <= duty_src;
      duty_pend_r <= 1'b0;
    end else if (hit(bus.addr, ADDR_DUTY) || hit(bus.addr, ADDR_MDUTY)) begin
      duty_pend_r <= 1'b1;
    end
  end

  // trigger start, roll count and postscaler
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      roll_r     <= ZERO6;
      post_en_r  <= 1'b0;
      div_cnt_r  <= ZERO3;
      trig_out_r <= 1'b0;
    end else begin
      trig_out_r <= 1'b0;
      if (boundary) begin
        roll_r <= roll_r + ONE6;
        if (roll_r == trg_r[B_TSTRT_HI:0]) post_en_r <= 1'b1;
      end
      if (hit(bus.addr, ADDR_TRG)) begin
        post_en_r <= 1'b0;
        roll_r    <= ZERO6;
        div_cnt_r <= ZERO3;
      end else if (trig_evt && post_en_r) begin
        if (div_cnt_r >= trg_r[B_TDIV_HI:B_TDIV_LO]) begin
          div_cnt_r  <= ZERO3;
          trig_out_r <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + ONE3;
        end
      end
    end
  end

  // pending bits: the clear by a disabled enable wins over the set
  logic lim_active, flt_active;
  assign lim_active = flt_r[B_LIM_EN] && LIMIT_IN;
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      limit_pend_r <= 1'b0;
      trg_pend_r   <= 1'b0;
    end else begin
      if (!ctrl_r[B_LIM_IEN]) limit_pend_r <= 1'b0;
      else if (lim_active) limit_pend_r <= 1'b1;
      if (!ctrl_r[B_TRG_IEN]) trg_pend_r <= 1'b0;
      else if (trig_out_r) trg_pend_r <= 1'b1;
    end
  end

  // fault: latched until a boundary with the input gone, or cycle-by-cycle
  ppwm_fmode_t fmode;
  assign fmode = ppwm_fmode_t'(flt_r[B_FMOD_HI:B_FMOD_LO]);
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      fault_lat_r <= 1'b0;
    end else begin
      case (fmode)
        FM_LATCH: fault_lat_r <= FAULT_IN || (fault_lat_r && !(boundary && !FAULT_IN));
        FM_CYCLE: fault_lat_r <= FAULT_IN || (fault_lat_r && !boundary);
        default:  fault_lat_r <= 1'b0;
      endcase
    end
  end
  assign flt_active = (fmode == FM_LATCH || fmode == FM_CYCLE) && (FAULT_IN || fault_lat_r);

  // raw waveform and output pair mode
  logic raw, half_r;
  assign raw = (tb_cnt_r < act_duty_r[CNT_W-1:0]);
  always_ff @(posedge MCLK) begin
    if (!RESET_N) half_r <= 1'b0;
    else if (boundary) half_r <= !half_r;
  end

  ppwm_pair_t dt_pair, gen_pair, force_req;
  ppwm_deadtime #(.DT_W(DT_W)) u_dt (
    .clk    (MCLK),
    .rst_n  (RESET_N),
    .raw    (raw),
    .mode   (ppwm_dtmode_t'(ctrl_r[B_DTM_HI:B_DTM_LO])),
    .dt_rise(dt_r[B_DT_LO +: DT_W]),
    .dt_fall(altdt_r[B_DT_LO +: DT_W]),
    .pair   (dt_pair)
  );

  always_comb begin
    case (ppwm_pmode_t'(io_r[B_PIN_PAIR_MODE_HI:B_PIN_PAIR_MODE_LO]))
      PM_COMP:  gen_pair = dt_pair;
      PM_INDEP: gen_pair = '{hi: raw, lo: raw};
      PM_PUSH:  gen_pair = '{hi: dt_pair.hi && !half_r, lo: dt_pair.hi && half_r};
      default:  gen_pair = '{hi: 1'b0, lo: 1'b0};
    endcase
  end

  // forced values: immediate or taken at the boundary
  assign force_req = '{hi: io_r[B_OVD_HI], lo: io_r[B_OVD_LO]};
  always_ff @(posedge MCLK) begin
    if (!RESET_N) force_act_r <= '{hi: 1'b0, lo: 1'b0};
    else if (!io_r[B_FORCE_SYNC_SELECT] || boundary) force_act_r <= force_req;
  end

  // priority select, then polarity, then ownership
  ppwm_pair_t sel;
  always_comb begin
    sel = gen_pair;
    if (io_r[B_OVRH]) sel.hi = force_act_r.hi;
    if (io_r[B_OVRL]) sel.lo = force_act_r.lo;
    if (lim_active) sel = '{hi: io_r[B_CLD_HI], lo: io_r[B_CLD_LO]};
    if (flt_active) sel = '{hi: io_r[B_FLD_HI], lo: io_r[B_FLD_LO]};
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      pins_r <= '{hi: 1'b0, lo: 1'b0};
    end else begin
      pins_r.hi <= io_r[B_HIGH_PIN_OWNER] ? (sel.hi ^ io_r[B_HIGH_PIN_INVERT]) : GPIO_HIGH;
      pins_r.lo <= io_r[B_LOW_PIN_OWNER] ? (sel.lo ^ io_r[B_POLL]) : GPIO_LOW;
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  logic [15:0] rd_mux;
  always_comb begin
    case (bus.addr)
      ADDR_CTRL:  rd_mux = ctrl_r | ({15'h0000, limit_pend_r} << B_LIM_PEND)
                                  | ({15'h0000, trg_pend_r} << B_TRG_PEND);
      ADDR_DUTY:  rd_mux = duty_r;
      ADDR_PHASE: rd_mux = phase_r;
      ADDR_DT:    rd_mux = dt_r;
      ADDR_ALTDT: rd_mux = altdt_r;
      ADDR_TRG:   rd_mux = trg_r;
      ADDR_IO:    rd_mux = io_r;
      ADDR_MDUTY: rd_mux = mduty_r;
      ADDR_PTPER: rd_mux = ptper_r;
      ADDR_FLT:   rd_mux = flt_r;
      default:    rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) rdata_r <= RST_ZERO;
    else if (bus.rd) rdata_r <= rd_mux;
    else rdata_r <= RST_ZERO;
  end

  assign RDATA           = rdata_r;
  assign HIGH_OUTPUT_PIN = pins_r.hi;
  assign LOW_OUTPUT_PIN  = pins_r.lo;
  assign TRIGGER_OUT     = trig_out_r;
  assign LIMIT_IRQ       = limit_pend_r;
  assign TRIGGER_IRQ     = trg_pend_r;
endmodule

// File: testbench/ppwm_channel_sva.sv
// ppwm_channel_sva: port-level assertions for one pwm channel.
// assumes a bind to ppwm_channel; sees only its ports.
module ppwm_channel_sva
  import ppwm_pkg::*;
(
  input wire logic              MCLK,
  input wire logic              RESET_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              TRIGGER_OUT,
  input wire logic              LIMIT_IRQ,
  input wire logic              TRIGGER_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence lim_off_wr;
    WR && ADDR == ADDR_CTRL && !WDATA[B_LIM_IEN];
  endsequence
  sequence trg_off_wr;
    WR && ADDR == ADDR_CTRL && !WDATA[B_TRG_IEN];
  endsequence
  // a pending flag may drop only after a write in this cycle or one of the two cycles before
  sequence no_recent_wr;
    !WR && !$past(WR) && !$past(WR, 2);
  endsequence
  AST_UNMAPPED_ZERO: assert property (RD && ADDR > ADDR_FLT |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  AST_CTRL_ZERO: assert property (RD && ADDR == ADDR_CTRL |=> (RDATA & 16'h903C) == 16'h0000)
    else $error("control spare bits not zero");
  AST_DT_ZERO: assert property (RD && (ADDR == ADDR_DT || ADDR == ADDR_ALTDT) |=> (RDATA & 16'hC003) == 16'h0000)
    else $error("dead time spare bits not zero");
  AST_TRG_ZERO: assert property (RD && ADDR == ADDR_TRG |=> (RDATA & 16'h1FC0) == 16'h0000)
    else $error("trigger spare bits not zero");
  AST_PHASE_ZERO: assert property (RD && ADDR == ADDR_PHASE |=> RDATA[1:0] == 2'h0)
    else $error("phase low bits not zero");
  AST_LIM_CLEAR: assert property (lim_off_wr |-> ##[1:2] !LIMIT_IRQ)
    else $error("limit pending not cleared");
  AST_TRG_CLEAR: assert property (trg_off_wr |-> ##[1:2] !TRIGGER_IRQ)
    else $error("trigger pending not cleared");
  AST_LIM_STICKY: assert property ((LIMIT_IRQ and no_recent_wr) |=> LIMIT_IRQ)
    else $error("limit pending dropped");
  AST_TRG_PULSE: assert property (TRIGGER_OUT |=> !TRIGGER_OUT)
    else $error("trigger output longer than one cycle");
  AST_RD_IDLE: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data without read");
endmodule

// File: testbench/ppwm_switch_model.sv
// ppwm_switch_model: half-bridge switch pair driven by the channel's pins.
// assumes active-high gates; both on together is a shoot-through.
module ppwm_switch_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        high_gate,
  input  wire logic        low_gate,
  output logic      [15:0] shoot_cnt,
  output logic      [15:0] edge_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_r;
  always_ff @(posedge clk) begin
    prev_r <= high_gate;
    if (!rst_n) begin
      shoot_cnt <= 16'h0000;
      edge_cnt  <= 16'h0000;
    end else begin
      if (high_gate && low_gate) shoot_cnt <= shoot_cnt + 16'h0001;
      if (high_gate && !prev_r) edge_cnt <= edge_cnt + 16'h0001;
    end
  end
endmodule

// File: testbench/ppwm_channel_tb.sv
// ppwm_channel_tb: register, pin, trigger and interrupt tests for one pwm channel.
// assumes the switch model on the pins and the checker bound below.
module ppwm_channel_tb;
  import ppwm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 0, RESET_N = 0, WR = 0, RD = 0, LIMIT_IN = 0, FAULT_IN = 0;
  logic GPIO_HIGH = 0, GPIO_LOW = 0, HIGH_OUTPUT_PIN, LOW_OUTPUT_PIN, TRIGGER_OUT, LIMIT_IRQ, TRIGGER_IRQ;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, RDATA, shoot, edges, s0, e0;
  int bad_count = 0, n_tests = 0, cyc = 0, p0, n, w1;
  logic [3:0]  t_a[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
  logic [15:0] t_r[11] = '{16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                           16'h0008, 16'hFFF8, 16'h0000, 16'h0000};
  logic [15:0] t_e[11] = '{16'h0FC3, 16'hFFEF, 16'hFFFC, 16'h3FFC, 16'h3FFC, 16'hE03F, 16'hFFFD,
                           16'hFFEF, 16'hFFF8, 16'h0083, 16'h0000};
  ppwm_channel dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LIMIT_IN(LIMIT_IN), .FAULT_IN(FAULT_IN), .GPIO_HIGH(GPIO_HIGH), .GPIO_LOW(GPIO_LOW),
    .HIGH_OUTPUT_PIN(HIGH_OUTPUT_PIN), .LOW_OUTPUT_PIN(LOW_OUTPUT_PIN), .TRIGGER_OUT(TRIGGER_OUT),
    .LIMIT_IRQ(LIMIT_IRQ), .TRIGGER_IRQ(TRIGGER_IRQ));
  ppwm_switch_model sw_u (.clk(MCLK), .rst_n(RESET_N), .high_gate(HIGH_OUTPUT_PIN),
    .low_gate(LOW_OUTPUT_PIN), .shoot_cnt(shoot), .edge_cnt(edges));
  always #12.5 MCLK = ~MCLK;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge MCLK);
    WR <= 1; ADDR <= a; WDATA <= d;
    @(posedge MCLK);
    WR <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge MCLK);
    RD <= 1; ADDR <= a;
    @(posedge MCLK);
    RD <= 0;
    #1 chk("rdata", exp, RDATA);
  endtask
  task automatic pins(logic [1:0] exp);
    tick(5);
    chk("pins", {14'h0000, exp}, {14'h0000, HIGH_OUTPUT_PIN, LOW_OUTPUT_PIN});
  endtask
  // cycles between two consecutive trigger pulses, after the first one seen
  // w0 counts cycles from the call to the first pulse; the call may come in the edge's time step
  task automatic gap(output int w0, output int g);
    w0 = 0;
    tick(0);
    while (TRIGGER_OUT !== 1'b1 && w0 < 20000) begin tick(1); w0++; end
    tick(1);
    g = 1;
    while (TRIGGER_OUT !== 1'b1 && g < 20000) begin tick(1); g++; end
  endtask
  initial begin
    tick(16);
    RESET_N <= 1;
    for (int i = 0; i < 11; i++) rd(t_a[i], t_r[i]);
    for (int i = 0; i < 11; i++) begin
      wr(t_a[i], (i == 1 || i == 7) ? 16'hFFEF : 16'hFFFF);
      rd(t_a[i], t_e[i]);
    end
    wr(ADDR_PTPER, 16'h0040);
    wr(ADDR_CTRL, 16'h0080);
    wr(ADDR_IO, 16'h0000);
    wr(ADDR_FLT, 16'h0003);
    wr(ADDR_DUTY, 16'h0020);
    wr(ADDR_PHASE, 16'h0010);
    GPIO_HIGH <= 1;
    pins(2'h2);
    GPIO_HIGH <= 0; GPIO_LOW <= 1;
    pins(2'h1);
    wr(ADDR_IO, 16'hC000);
    tick(5);
    s0 = shoot; e0 = edges;
    tick(300);
    chk("shoot", s0, shoot);
    chk("edges", 16'h0001, {15'h0000, (edges - e0) >= 16'h0004});
    wr(ADDR_IO, 16'hC380);
    pins(2'h2);
    wr(ADDR_IO, 16'hF380);
    pins(2'h1);
    wr(ADDR_IO, 16'hC304);
    wr(ADDR_FLT, 16'h0083);
    LIMIT_IN <= 1;
    pins(2'h1);
    wr(ADDR_IO, 16'hC334);
    wr(ADDR_FLT, 16'h0081);
    FAULT_IN <= 1;
    pins(2'h3);
    FAULT_IN <= 0; LIMIT_IN <= 0;
    // cycle-by-cycle mode: the held fault must let go at the next boundary
    wr(ADDR_FLT, 16'h0001);
    tick(150);
    pins(2'h0);
    wr(ADDR_CTRL, 16'h0880);
    wr(ADDR_FLT, 16'h0083);
    LIMIT_IN <= 1;
    tick(3);
    LIMIT_IN <= 0;
    tick(20);
    chk("limit_irq", 16'h0001, {15'h0000, LIMIT_IRQ});
    rd(ADDR_CTRL, 16'h4880);
    wr(ADDR_CTRL, 16'h0080);
    tick(3);
    chk("limit_irq", 16'h0000, {15'h0000, LIMIT_IRQ});
    rd(ADDR_CTRL, 16'h0080);
    wr(ADDR_TRG, 16'h0000);
    gap(w1, p0);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_TRG, (k == 0) ? 16'h2000 : 16'hE000);
      gap(w1, n);
      chk("trg_gap", 16'(p0 * ((k == 0) ? 2 : 8)), 16'(n));
    end
    // start count 3: no pulse until the fourth boundary after the write
    wr(ADDR_TRG, 16'h0003);
    gap(w1, n);
    chk("trg_start", 16'h0001, {15'h0000, (w1 >= 200 && w1 <= 290)});
    wr(ADDR_CTRL, 16'h0480);
    gap(w1, n);
    tick(4);
    chk("trg_irq", 16'h0001, {15'h0000, TRIGGER_IRQ});
    rd(ADDR_CTRL, 16'h2480);
    wr(ADDR_CTRL, 16'h0080);
    tick(3);
    chk("trg_irq", 16'h0000, {15'h0000, TRIGGER_IRQ});
    // independent period from the phase register: 0x30 gives 49 cycles
    wr(ADDR_PHASE, 16'h0030);
    wr(ADDR_CTRL, 16'h0280);
    gap(w1, n);
    chk("itb_gap", 16'h0031, 16'(n));
    // limit source held high keeps the independent time base at zero
    wr(ADDR_CTRL, 16'h0282);
    LIMIT_IN <= 1;
    tick(2);
    n = 0;
    repeat (150) begin
      tick(1);
      n += TRIGGER_OUT;
    end
    chk("xres_trg", 16'h0000, 16'(n));
    LIMIT_IN <= 0;
    close_out();
  end
endmodule
bind ppwm_channel ppwm_channel_sva chk_u (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .TRIGGER_OUT(TRIGGER_OUT), .LIMIT_IRQ(LIMIT_IRQ),
  .TRIGGER_IRQ(TRIGGER_IRQ));
